// ---- rtl/p3mux_top.sv ----
`timescale 1ns/10ps
module p3mux_top (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [p3mux_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // pads
  input wire logic [7:0] i_pin_in,
  output p3mux_pkg::p3mux_pins_t o_pins,
  // serial interface unit
  input wire logic i_serial_transmit_data,
  input wire logic i_serial_master_clock,
  output p3mux_pkg::p3mux_serial_t o_serial
);
  import p3mux_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] port3_function_select_q;
  logic [7:0] port3_direction_q;
  logic [7:0] port3_output_value_q;
  p3mux_mode_t mode_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic clk_prev_q;
  p3mux_pins_t pins_q;
  p3mux_pins_t pins_d;
  p3mux_serial_t serial_q;
  p3mux_serial_t serial_d;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [31:0] rdata_d;

  assign req = i_read | i_write;
  assign rd_go = i_read & wait_q;
  assign wr_go = i_write & ~wait_q & i_byteenable[0];

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then one cycle with waitrequest low
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      wait_q <= 1'b1;
    else
      wait_q <= ~(req & wait_q);
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unique case (i_address)
      OFS_FUNCTION_SELECT: rdata_d[7:0] = port3_function_select_q;
      OFS_DIRECTION: rdata_d[7:0] = port3_direction_q;
      OFS_OUTPUT_VALUE: rdata_d[7:0] = port3_output_value_q;
      OFS_INPUT_VALUE: rdata_d[7:0] = sync2_q;
      OFS_SERIAL_MODE: rdata_d[1:0] = mode_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // data captured while waitrequest is still high, so it stands at the
  // edge where the master sees waitrequest low
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      rdata_q <= 32'h0000_0000;
    else if (rd_go)
      rdata_q <= rdata_d;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      port3_function_select_q <= RST_SELECT;
      port3_direction_q <= RST_DIRECTION;
      port3_output_value_q <= RST_OUTPUT;
      mode_q <= P3MUX_ASYNC;
    end
    else if (wr_go)
    begin
      unique case (i_address)
        OFS_FUNCTION_SELECT: port3_function_select_q <= i_writedata[7:0];
        OFS_DIRECTION: port3_direction_q <= i_writedata[7:0];
        OFS_OUTPUT_VALUE: port3_output_value_q <= i_writedata[7:0];
        // reserved code 2'b10 is stored as async, the safe direction
        OFS_SERIAL_MODE: mode_q <= (i_writedata[1:0] == 2'h2) ?
          P3MUX_ASYNC : p3mux_mode_t'(i_writedata[1:0]);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pad synchronisers and shift clock edge finder
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= i_pin_in;
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q[PIN_CLK];
    end
  end

  // ----------------------------------------------------------------
  // pin multiplexing
  // ----------------------------------------------------------------
  always_comb
  begin
    // plain port by default; pins 1 and 2 never leave this
    pins_d.out = port3_output_value_q;
    pins_d.oe_n = ~port3_direction_q;
    if (port3_function_select_q[PIN_STE])
    begin
      pins_d.oe_n[PIN_STE] = 1'b1;
      pins_d.out[PIN_STE] = 1'b0;
    end
    if (port3_function_select_q[PIN_TXD])
    begin
      pins_d.oe_n[PIN_TXD] = 1'b0;
      pins_d.out[PIN_TXD] = i_serial_transmit_data;
    end
    if (port3_function_select_q[PIN_RXD])
    begin
      pins_d.oe_n[PIN_RXD] = 1'b1;
      pins_d.out[PIN_RXD] = 1'b0;
    end
    // spare pins keep their own direction bit
    if (port3_function_select_q[PIN_SP6])
      pins_d.out[PIN_SP6] = 1'b0;
    if (port3_function_select_q[PIN_SP7])
      pins_d.out[PIN_SP7] = 1'b0;
    if (port3_function_select_q[PIN_CLK])
    begin
      if (mode_q == P3MUX_MASTER)
      begin
        pins_d.oe_n[PIN_CLK] = 1'b0;
        pins_d.out[PIN_CLK] = i_serial_master_clock;
      end
      else
      begin
        // async and slave both listen only
        pins_d.oe_n[PIN_CLK] = 1'b1;
        pins_d.out[PIN_CLK] = 1'b0;
      end
    end
  end

  always_comb
  begin
    serial_d.receive_data = port3_function_select_q[PIN_RXD] ?
      sync2_q[PIN_RXD] : 1'b1;
    serial_d.slave_transmit_enable = port3_function_select_q[PIN_STE] &
      sync2_q[PIN_STE];
    serial_d.shift_clock = port3_function_select_q[PIN_CLK] &
      sync2_q[PIN_CLK];
    // edges only in slave mode; shift_clock still follows the pin read back in master mode
    serial_d.shift_clock_rise = port3_function_select_q[PIN_CLK] &
      (mode_q == P3MUX_SLAVE) & sync2_q[PIN_CLK] & ~clk_prev_q;
    serial_d.shift_clock_fall = port3_function_select_q[PIN_CLK] &
      (mode_q == P3MUX_SLAVE) & ~sync2_q[PIN_CLK] & clk_prev_q;
  end

  // ----------------------------------------------------------------
  // output flops; pads idle as inputs under reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      pins_q.out <= 8'h00;
      pins_q.oe_n <= 8'hff;
      serial_q <= '0;
    end
    else
    begin
      pins_q <= pins_d;
      serial_q <= serial_d;
    end
  end

  assign o_pins = pins_q;
  assign o_serial = serial_q;
  assign o_readdata = rdata_q;
  assign o_waitrequest = wait_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  chk_txd_driven: assert property (
    port3_function_select_q[PIN_TXD] |=> !o_pins.oe_n[PIN_TXD] &&
      o_pins.out[PIN_TXD] == $past(i_serial_transmit_data))
    else $error("transmit pin not driven by serial data");

  chk_rxd_routed: assert property (
    port3_function_select_q[PIN_RXD] ##1 port3_function_select_q[PIN_RXD]
      |=> o_pins.oe_n[PIN_RXD] && !o_pins.out[PIN_RXD] &&
      o_serial.receive_data == $past(i_pin_in[PIN_RXD], 3))
    else $error("receive pin not routed as input");

  chk_ste_routed: assert property (
    port3_function_select_q[PIN_STE] |=> o_pins.oe_n[PIN_STE] &&
      !o_pins.out[PIN_STE] &&
      o_serial.slave_transmit_enable == $past(sync2_q[PIN_STE]))
    else $error("slave enable pin not routed as input");

  chk_spare_dir: assert property (
    port3_function_select_q[PIN_SP6] |=> !o_pins.out[PIN_SP6] &&
      o_pins.oe_n[PIN_SP6] == !$past(port3_direction_q[PIN_SP6]))
    else $error("spare pin direction or level wrong");

  chk_async_clk_in: assert property (
    port3_function_select_q[PIN_CLK] && mode_q == P3MUX_ASYNC
      |=> o_pins.oe_n[PIN_CLK])
    else $error("clock pin driven in async mode");

  chk_slave_edge: assert property (
    port3_function_select_q[PIN_CLK] && mode_q == P3MUX_SLAVE &&
      sync2_q[PIN_CLK] && !clk_prev_q |=> o_serial.shift_clock_rise
      ##1 !o_serial.shift_clock_rise)
    else $error("slave clock edge missed or stretched");

  chk_master_clk: assert property (
    port3_function_select_q[PIN_CLK] && mode_q == P3MUX_MASTER
      |=> !o_pins.oe_n[PIN_CLK] &&
      o_pins.out[PIN_CLK] == $past(i_serial_master_clock))
    else $error("master clock not driven out");

  chk_plain_port: assert property (
    !port3_function_select_q[1] |=> o_pins.out[1] ==
      $past(port3_output_value_q[1]) &&
      o_pins.oe_n[1] == !$past(port3_direction_q[1]))
    else $error("plain port pin wrong");

  chk_bus_answer: assert property (
    req && wait_q |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus answer not one cycle");

  cov_master: cover property (!o_pins.oe_n[PIN_CLK] &&
    port3_function_select_q[PIN_CLK] && mode_q == P3MUX_MASTER);
  cov_slave_fall: cover property (o_serial.shift_clock_fall);
  cov_txd: cover property (port3_function_select_q[PIN_TXD] &&
    o_pins.out[PIN_TXD]);
  cov_write: cover property (wr_go);

endmodule

// ---- shared/p3mux_pkg.sv ----
// How it works
// - pin 4 selected: output, transmit data
// - pin 5 selected: input to receive, out low
// - pin 0 selected: input to slave enable, out low
// - pins 6,7 selected: direction bit kept, out low
// - asynchronous mode: pin 3, when selected, never driven
// - slave mode: external clock edges shift data
// - master mode: own clock driven on pin
package p3mux_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_FUNCTION_SELECT = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_VALUE = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_INPUT_VALUE = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_SERIAL_MODE = 5'h10;

  // ----------------------------------------------------------------
  // pin positions
  // ----------------------------------------------------------------
  localparam int PIN_STE = 0;
  localparam int PIN_CLK = 3;
  localparam int PIN_TXD = 4;
  localparam int PIN_RXD = 5;
  localparam int PIN_SP6 = 6;
  localparam int PIN_SP7 = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SELECT = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_OUTPUT = 8'h00;
  localparam logic [2:0] RST_SYNC = 3'h0;

  // serial mode, gray along async -> slave -> master; 2'b10 acts async
  typedef enum logic [1:0] {
    P3MUX_ASYNC = 2'h0,
    P3MUX_SLAVE = 2'h1,
    P3MUX_MASTER = 2'h3
  } p3mux_mode_t;

  // pad side of the eight pins; oe_n low while the pin is driven
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } p3mux_pins_t;

  // signals handed to the serial interface unit
  typedef struct packed {
    logic receive_data;
    logic slave_transmit_enable;
    logic shift_clock;
    logic shift_clock_rise;
    logic shift_clock_fall;
  } p3mux_serial_t;

endpackage

// ---- verif/p3mux_far_model.sv ----
`timescale 1ns/10ps
module p3mux_far_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // bench controls
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_en,
  input wire logic i_run,
  input wire logic i_ext_clk,
  // pads
  input wire p3mux_pkg::p3mux_pins_t i_pins,
  output logic [7:0] o_pin_in,
  // link clock, 160 ns
  output logic o_link_clk
);
  import p3mux_pkg::*;
  // ----------------------------------------
  // link clock and floating pattern
  // ----------------------------------------
  logic [1:0] cnt_q;
  logic flt_q;
  // stands at 0 between frames, so no stray edge
  always_ff @(posedge i_clock)
  begin
    flt_q <= i_rst ? 1'b0 : !flt_q;
    if (i_rst || !i_run)
    begin
      cnt_q <= 2'h0;
      o_link_clk <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h3)
        o_link_clk <= !o_link_clk;
    end
  end
  // released pads toggle: a stale level must not pass
  always_comb
    for (int i = 0; i < 8; i++)
      o_pin_in[i] = !i_pins.oe_n[i] ? i_pins.out[i] :
        (i_ext_clk && i == PIN_CLK) ? o_link_clk :
        i_ext_en[i] ? i_ext_val[i] : flt_q;
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/10ps
module tb;
  import p3mux_pkg::*;
  logic i_clock = 0, i_rst = 1, i_read = 0, i_write = 0;
  logic txd = 0, run = 0, eclk = 0, cnt_on = 0, prev, wq, lclk;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0] wd = '0, rd;
  logic [3:0] be = 4'hf;
  logic [7:0] ev = 8'h00, een = 8'h00, pin_in;
  p3mux_pins_t pins;
  p3mux_serial_t ser;
  int n_fail = 0, compares = 0, nrise = 0, nfall = 0;

  p3mux_top u_p3mux_top (.i_clock(i_clock), .i_rst(i_rst),
    .i_address(adr), .i_read(i_read), .i_write(i_write),
    .i_writedata(wd), .i_byteenable(be), .o_readdata(rd),
    .o_waitrequest(wq), .i_pin_in(pin_in), .o_pins(pins),
    .i_serial_transmit_data(txd), .i_serial_master_clock(lclk),
    .o_serial(ser));
  p3mux_far_model u_p3mux_far_model (.i_clock(i_clock),
    .i_rst(i_rst), .i_ext_val(ev), .i_ext_en(een), .i_run(run),
    .i_ext_clk(eclk), .i_pins(pins), .o_pin_in(pin_in),
    .o_link_clk(lclk));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // one edge passes after release, so calls never collide
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q);
    adr <= a;
    wd <= d;
    i_write <= w;
    i_read <= !w;
    // waits as long as the slave asks; only the watchdog ends a hang
    @(posedge i_clock);
    while (wq !== 1'b0)
      @(posedge i_clock);
    q = rd;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  task close_out;
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, pulse counter
  // ----------------------------------------
  initial
    forever #10 i_clock = !i_clock;
  initial
  begin
    #200000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    close_out;
  end
  always @(posedge i_clock)
    if (cnt_on)
    begin
      nrise += ser.shift_clock_rise;
      nfall += ser.shift_clock_fall;
    end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    wt(10);
    i_rst <= 1'b0;
    wt(1);
    check(pins, 16'h00ff);
    rdchk(OFS_FUNCTION_SELECT, 32'h0);
    rdchk(OFS_DIRECTION, 32'h0);
    rdchk(5'h14, 32'h0);
    wr(OFS_DIRECTION, 32'hf0);
    wr(OFS_OUTPUT_VALUE, 32'ha5);
    ev <= 8'h3c;
    een <= 8'h0f;
    be <= 4'he;
    wr(OFS_DIRECTION, 32'hff);
    be <= 4'hf;
    wt(4);
    check(pins.oe_n, 8'h0f);
    check(pins.out & 8'hf0, 8'ha0);
    rdchk(OFS_INPUT_VALUE, 32'hac);
    // output register all ones: forced lows must win
    wr(OFS_FUNCTION_SELECT, 32'hf1);
    wr(OFS_DIRECTION, 32'h6f);
    wr(OFS_OUTPUT_VALUE, 32'hff);
    een <= 8'h21;
    for (int i = 0; i < 2; i++)
    begin
      txd <= i[0];
      ev <= i[0] ? 8'h01 : 8'h20;
      wt(5);
      check(pins.oe_n, 8'ha1);
      check(pins.out & 8'hf1, {3'h0, i[0], 4'h0});
      check(ser.receive_data, !i[0]);
      check(ser.slave_transmit_enable, i[0]);
    end
    wr(OFS_FUNCTION_SELECT, 32'h08);
    for (int m = 0; m < 3; m += 2)
    begin
      wr(OFS_SERIAL_MODE, m);
      rdchk(OFS_SERIAL_MODE, 32'h0);
      wt(2);
      check(pins.oe_n[PIN_CLK], 1'b1);
    end
    wr(OFS_SERIAL_MODE, 32'h3);
    run <= 1'b1;
    wt(3);
    prev = lclk;
    repeat (16)
    begin
      @(posedge i_clock);
      check(pins.oe_n[PIN_CLK], 1'b0);
      check(pins.out[PIN_CLK], prev);
      prev = lclk;
    end
    run <= 1'b0;
    wr(OFS_SERIAL_MODE, 32'h1);
    eclk <= 1'b1;
    wt(4);
    cnt_on <= 1'b1;
    run <= 1'b1;
    wt(16);
    check(ser.shift_clock, 1'b1);
    wt(16);
    run <= 1'b0;
    wt(8);
    cnt_on <= 1'b0;
    check(ser.shift_clock, 1'b0);
    check(nrise, 4);
    check(nfall, 4);
    check(pins.oe_n[PIN_CLK], 1'b1);
    close_out;
  end
endmodule
